// ### logic/acc_channel_regs.sv
// channel configuration register bank on ahb-lite with steered outputs
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module acc_channel_regs
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // channel 1 signal path
  input  wire logic        mod_tick,
  input  wire logic        ch1_sample_in,
  output logic             ch1_sample_out,
  output logic             ch1_muted,
  output logic signed [11:0] ch1_volume_tenth_db,
  output logic signed [7:0]  ch1_gain_tenth_db,
  // channel 2 front end
  output logic             ch2_source_kind,
  output logic [1:0]       ch2_input_source,
  output logic             ch2_source_analog,
  output logic             ch2_coupling_select,
  output logic [1:0]       ch2_input_load_select,
  output logic             ch2_config_fault,
  output logic             range_enhancer,
  output logic             automatic_level_control,
  output logic             range_compressor
);

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    logic [7:0]  ch1_volume;
    logic [7:0]  ch1_gain;
    logic [7:0]  ch1_phase;
    logic [7:0]  ch2_input;
    logic [7:0]  dyn_mode;
    logic        dp_write;
    logic [7:0]  dp_index;
    logic [31:0] rdata;
    logic signed [11:0] vol_db;
    logic signed [7:0]  gain_db;
    logic        muted;
    acc_dyn_e    dyn;
  } acc_regs_s;

  acc_regs_s st_ff;
  acc_regs_s nxt_st;

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic logic [7:0] acc_index(input logic [31:0] a);
    acc_index = a[9:2];
  endfunction

  function automatic logic [7:0] acc_read(input acc_regs_s s,
                                          input logic [7:0] idx);
    acc_read = 8'h00;
    unique case (idx)
      ACC_IDX_CH1_VOLUME: acc_read = s.ch1_volume;
      ACC_IDX_CH1_GAIN:   acc_read = s.ch1_gain & ACC_GAIN_MASK;
      ACC_IDX_CH1_PHASE:  acc_read = s.ch1_phase;
      ACC_IDX_CH2_INPUT:  acc_read = s.ch2_input & ACC_INPUT_MASK;
      ACC_IDX_DYN_MODE:   acc_read = s.dyn_mode & ACC_DYN_MASK;
      default:            acc_read = 8'h00;
    endcase
  endfunction

  // linear step from a unity code, one step per code count
  function automatic logic signed [11:0] acc_step(input logic [7:0] code,
                                                  input logic [7:0] unity,
                                                  input int         step);
    int diff;
    diff = (int'(code) - int'(unity)) * step;
    acc_step = diff[11:0];
  endfunction

  // ******************************************************
  // bus and register update
  // ******************************************************
  logic       take;
  logic [7:0] wbyte;
  logic signed [11:0] gain_wide;

  assign take  = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];

  always_comb begin
    nxt_st = st_ff;
    gain_wide = '0;
    // data phase of a write lands in the addressed register
    if (st_ff.dp_write) begin
      unique case (st_ff.dp_index)
        ACC_IDX_CH1_VOLUME: nxt_st.ch1_volume = wbyte;
        // reserved nibble kept at zero whatever is written
        ACC_IDX_CH1_GAIN:   nxt_st.ch1_gain = wbyte & ACC_GAIN_MASK;
        ACC_IDX_CH1_PHASE:  nxt_st.ch1_phase = wbyte;
        ACC_IDX_CH2_INPUT:  nxt_st.ch2_input = wbyte & ACC_INPUT_MASK;
        ACC_IDX_DYN_MODE:   nxt_st.dyn_mode = wbyte & ACC_DYN_MASK;
        default: ;
      endcase
    end
    nxt_st.dp_write = take && hwrite;
    nxt_st.dp_index = acc_index(haddr);
    if (take && !hwrite) begin
      nxt_st.rdata = {24'h000000, acc_read(st_ff, acc_index(haddr))};
    end
    // decoded settings, registered so outputs come from flops
    nxt_st.muted  = (nxt_st.ch1_volume == ACC_VOL_MUTE_CODE);
    nxt_st.vol_db = acc_step(nxt_st.ch1_volume, ACC_VOL_UNITY_CODE,
                             ACC_VOL_STEP_TENTH);
    gain_wide = acc_step({4'h0, nxt_st.ch1_gain[7:ACC_GAIN_LSB]},
                         {4'h0, ACC_GAIN_UNITY_CODE},
                         ACC_GAIN_STEP_TENTH);
    nxt_st.gain_db = gain_wide[7:0];
    if (!nxt_st.ch2_input[ACC_BOOST_BIT]) begin
      nxt_st.dyn = ACC_DYN_OFF;
    end else if (nxt_st.dyn_mode[ACC_DYN_SEL_BIT]) begin
      nxt_st.dyn = ACC_DYN_ALT;
    end else begin
      nxt_st.dyn = ACC_DYN_ENH;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff.ch1_volume <= ACC_RST_CH1_VOLUME;
      st_ff.ch1_gain   <= ACC_RST_CH1_GAIN;
      st_ff.ch1_phase  <= ACC_RST_CH1_PHASE;
      st_ff.ch2_input  <= ACC_RST_CH2_INPUT;
      st_ff.dyn_mode   <= ACC_RST_DYN_MODE;
      st_ff.dp_write   <= 1'b0;
      st_ff.dp_index   <= 8'h00;
      st_ff.rdata      <= 32'h00000000;
      st_ff.vol_db     <= 12'h000;
      st_ff.gain_db    <= 8'h00;
      st_ff.muted      <= 1'b0;
      st_ff.dyn        <= ACC_DYN_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdata;

  // ******************************************************
  // channel 1 path
  // ******************************************************
  logic delayed;

  acc_phase_delay u_phase (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .mod_tick   (mod_tick),
    .sample_in  (ch1_sample_in),
    .delay_code (st_ff.ch1_phase),
    .sample_out (delayed)
  );

  // muting forces the stream low rather than any attenuation step
  assign ch1_sample_out      = delayed & ~st_ff.muted;
  assign ch1_muted           = st_ff.muted;
  assign ch1_volume_tenth_db = st_ff.muted ? 12'sh000 : st_ff.vol_db;
  assign ch1_gain_tenth_db   = st_ff.gain_db;

  // ******************************************************
  // channel 2 front end
  // ******************************************************
  logic [1:0] src;
  logic [1:0] load;
  assign src  = st_ff.ch2_input[ACC_SRC_LSB +: 2];
  assign load = st_ff.ch2_input[ACC_LOAD_LSB +: 2];

  assign ch2_source_kind   = st_ff.ch2_input[ACC_KIND_BIT];
  assign ch2_input_source  = src;
  assign ch2_source_analog = (src == ACC_SRC_DIFF) ||
                             (src == ACC_SRC_SINGLE);
  // coupling and load only reach the analog front end
  assign ch2_coupling_select = ch2_source_analog &
                               st_ff.ch2_input[ACC_COUPLE_BIT];
  assign ch2_input_load_select = ch2_source_analog ? load
                                                   : 2'h0;
  // reserved codes are flagged, the hardware does not repair them
  assign ch2_config_fault = (src == ACC_SRC_RESERVED) ||
                            (load == ACC_LOAD_RESERVED);
  assign range_enhancer          = (st_ff.dyn == ACC_DYN_ENH);
  assign automatic_level_control = (st_ff.dyn == ACC_DYN_ALT);
  assign range_compressor        = 1'b0;

  // ******************************************************
  // assertions
  // ******************************************************
  sequence s_vol_write(logic [7:0] v);
    st_ff.dp_write && st_ff.dp_index == ACC_IDX_CH1_VOLUME && wbyte == v;
  endsequence

  sequence s_gain_write(logic [3:0] g);
    st_ff.dp_write && st_ff.dp_index == ACC_IDX_CH1_GAIN &&
      wbyte[7:4] == g;
  endsequence

  sequence s_reg_write(logic [7:0] idx);
    st_ff.dp_write && st_ff.dp_index == idx;
  endsequence

  sequence s_reg_read(logic [7:0] idx);
    take && !hwrite && acc_index(haddr) == idx;
  endsequence

  a_mute_on_zero: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_vol_write(8'h00) |=> ##1 (ch1_muted && !ch1_sample_out))
    else $error("volume zero did not mute");

  a_mute_forces: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ch1_muted |-> (!ch1_sample_out && ch1_volume_tenth_db == 12'sh000))
    else $error("muted channel still passes level");

  a_vol_unity: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_vol_write(8'hC9) |=> ##1 (ch1_volume_tenth_db == 12'sh000))
    else $error("volume 201 not unity");

  a_vol_floor: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_vol_write(8'h01) |=> ##1 (ch1_volume_tenth_db == -12'sd1000))
    else $error("volume 1 not -100 dB");

  a_vol_top: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_vol_write(8'hFF) |=> (ch1_volume_tenth_db == 12'sd270))
    else $error("volume 255 not +27 dB");

  a_vol_step: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (!ch1_muted) |-> (ch1_volume_tenth_db ==
      (12'(st_ff.ch1_volume) - 12'd201) * 12'sd5))
    else $error("volume step not half dB");

  a_vol_readback: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_reg_read(ACC_IDX_CH1_VOLUME) |=>
      (hrdata == {24'h000000, $past(st_ff.ch1_volume)}))
    else $error("volume readback wrong");

  a_gain_map: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ch1_gain_tenth_db == 8'(8'(st_ff.ch1_gain[7:4]) - 8'd8))
    else $error("gain trim step wrong");

  a_gain_floor: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_gain_write(4'h0) |=> (ch1_gain_tenth_db == -8'sd8))
    else $error("gain trim 0 not -0.8 dB");

  a_gain_unity: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_gain_write(4'h8) |=> (ch1_gain_tenth_db == 8'sh00))
    else $error("gain trim 8 not unity");

  a_gain_top: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_gain_write(4'hF) |=> (ch1_gain_tenth_db == 8'sd7))
    else $error("gain trim 15 not +0.7 dB");

  a_gain_nibble: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_reg_read(ACC_IDX_CH1_GAIN) |=> (hrdata[3:0] == 4'h0))
    else $error("gain reserved bits read nonzero");

  a_gain_lands: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_reg_write(ACC_IDX_CH1_GAIN) |=>
      (st_ff.ch1_gain == {$past(wbyte[7:4]), 4'h0}))
    else $error("gain trim write did not land");

  a_phase_lands: assert property (@(posedge hclk)
    disable iff (!hresetn)
    s_reg_write(ACC_IDX_CH1_PHASE) |=> (st_ff.ch1_phase == $past(wbyte)))
    else $error("phase trim write did not land");

  a_kind_bit: assert property (@(posedge hclk)
    disable iff (!hresetn)
    ch2_source_kind == st_ff.ch2_input[7])
    else $error("input kind not bit 7");

  a_src_reserved: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ch2_input_source == 2'h3) |-> ch2_config_fault)
    else $error("reserved source not flagged");

  a_digital_no_couple: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ch2_input_source == ACC_SRC_PDM) |-> !ch2_coupling_select)
    else $error("coupling applied to pdm input");

  a_pdm_no_load: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ch2_input_source == ACC_SRC_PDM) |->
      (!ch2_source_analog && ch2_input_load_select == 2'h0))
    else $error("load applied to pdm input");

  a_load_reserved: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (ch2_input_load_select == 2'h3) |-> ch2_config_fault)
    else $error("reserved load not flagged");

  a_dyn_gate: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (!st_ff.ch2_input[0]) |-> (!range_enhancer && !automatic_level_control))
    else $error("dynamics active while disabled");

  a_dyn_pick_enh: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (st_ff.ch2_input[0] && !st_ff.dyn_mode[3]) |-> range_enhancer)
    else $error("enhancer not chosen by mode bit");

  a_dyn_pick_alc: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (st_ff.ch2_input[0] && st_ff.dyn_mode[3]) |-> automatic_level_control)
    else $error("level control not chosen by mode bit");

  a_dyn_onehot: assert property (@(posedge hclk)
    disable iff (!hresetn)
    !(range_enhancer && automatic_level_control) && !range_compressor)
    else $error("more than one dynamics feature on");

endmodule

// ### logic/acc_pkg.sv
// package: register map, field layout and step constants for channel config
package acc_pkg;

  // ******************************************************
  // register word indices, haddr[9:2] (printed offsets are indices)
  // ******************************************************
  localparam logic [7:0] ACC_IDX_CH1_VOLUME  = 8'h3E;
  localparam logic [7:0] ACC_IDX_CH1_GAIN    = 8'h3F;
  localparam logic [7:0] ACC_IDX_CH1_PHASE   = 8'h40;
  localparam logic [7:0] ACC_IDX_CH2_INPUT   = 8'h41;
  localparam logic [7:0] ACC_IDX_DYN_MODE    = 8'h6C;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [7:0] ACC_RST_CH1_VOLUME  = 8'hC9;
  localparam logic [7:0] ACC_RST_CH1_GAIN    = 8'h80;
  localparam logic [7:0] ACC_RST_CH1_PHASE   = 8'h00;
  localparam logic [7:0] ACC_RST_CH2_INPUT   = 8'h00;
  localparam logic [7:0] ACC_RST_DYN_MODE    = 8'h00;

  // ******************************************************
  // field positions and masks
  // ******************************************************
  localparam int         ACC_GAIN_LSB        = 4;
  localparam logic [7:0] ACC_GAIN_MASK       = 8'hF0;
  localparam int         ACC_KIND_BIT        = 7;
  localparam int         ACC_SRC_LSB         = 5;
  localparam int         ACC_COUPLE_BIT      = 4;
  localparam int         ACC_LOAD_LSB        = 2;
  localparam int         ACC_BOOST_BIT       = 0;
  localparam logic [7:0] ACC_INPUT_MASK      = 8'hFD;
  localparam int         ACC_DYN_SEL_BIT     = 3;
  localparam logic [7:0] ACC_DYN_MASK        = 8'h08;

  // ******************************************************
  // step arithmetic (tenths of a dB)
  // ******************************************************
  localparam logic [7:0] ACC_VOL_MUTE_CODE   = 8'h00;
  localparam logic [7:0] ACC_VOL_UNITY_CODE  = 8'hC9;
  localparam int         ACC_VOL_STEP_TENTH  = 5;
  localparam logic [3:0] ACC_GAIN_UNITY_CODE = 4'h8;
  localparam int         ACC_GAIN_STEP_TENTH = 1;

  // ******************************************************
  // enumerations
  // ******************************************************
  localparam logic [1:0] ACC_SRC_DIFF        = 2'h0;
  localparam logic [1:0] ACC_SRC_SINGLE      = 2'h1;
  localparam logic [1:0] ACC_SRC_PDM         = 2'h2;
  localparam logic [1:0] ACC_SRC_RESERVED    = 2'h3;
  localparam logic [1:0] ACC_LOAD_RESERVED   = 2'h3;

  typedef enum logic [2:0] {
    ACC_DYN_OFF  = 3'b001,
    ACC_DYN_ENH  = 3'b010,
    ACC_DYN_ALT  = 3'b100
  } acc_dyn_e;

  // ******************************************************
  // ahb constants
  // ******************************************************
  localparam logic [1:0] ACC_HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0] ACC_HTRANS_SEQ      = 2'h3;

endpackage

// ### logic/acc_phase_delay.sv
// 256-entry sample delay line stepped by the modulator sample strobe, 8-bit delay code
`timescale 1ns/100ps
module acc_phase_delay
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // sample stream
  input  wire logic       mod_tick,
  input  wire logic       sample_in,
  input  wire logic [7:0] delay_code,
  output logic            sample_out
);

  typedef struct packed {
    logic [255:0] line;
    logic         out;
  } acc_dly_s;

  acc_dly_s st_ff;
  acc_dly_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (mod_tick) begin
      nxt_st.line = {st_ff.line[254:0], sample_in};
      // code 0 passes straight through, code n looks n ticks back
      if (delay_code == 8'h00) begin
        nxt_st.out = sample_in;
      end else begin
        nxt_st.out = st_ff.line[delay_code - 8'h01];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sample_out = st_ff.out;

  // assertion: a code of zero means no delay at all
  a_zero_delay_pass: assert property (@(posedge hclk)
    disable iff (!hresetn)
    (mod_tick && delay_code == 8'h00) |=> (sample_out == $past(sample_in)))
    else $error("zero phase code did not pass sample through");

endmodule

// ### verif/tb_top.sv
// testbench: channel configuration register bank over ahb-lite
`timescale 1ns/100ps
module tb_top
  import acc_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h00000000;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h00000000;
  logic               mod_tick = 1'b0;
  logic               ch1_sample_in = 1'b0;
  wire logic          hready;
  logic [31:0]        hrdata;
  logic               hreadyout, hresp, ch1_sample_out, ch1_muted;
  logic signed [11:0] ch1_volume_tenth_db;
  logic signed [7:0]  ch1_gain_tenth_db;
  logic               ch2_source_kind, ch2_source_analog;
  logic               ch2_coupling_select, ch2_config_fault;
  logic [1:0]         ch2_input_source, ch2_input_load_select;
  logic               range_enhancer, automatic_level_control;
  logic               range_compressor;
  int                 mismatches = 0;
  int                 tests_run = 0;
  int                 e;
  logic [31:0]        rd;
  logic [5:0]         c;
  logic               an;
  logic [10:0]        ex2;
  logic               hist[$];
  typedef struct packed {
    logic [31:0] a;
    logic [7:0]  w;
    logic [7:0]  r;
  } acc_tb_row_s;
  // reserved bits read zero, unmapped place ignores writes
  acc_tb_row_s rows [8] = '{
    '{32'h000000F8, 8'h00, 8'h00}, '{32'h000000F8, 8'hFF, 8'hFF},
    '{32'h000000FC, 8'hFF, 8'hF0}, '{32'h000000FC, 8'h0F, 8'h00},
    '{32'h00000100, 8'hA5, 8'hA5}, '{32'h00000104, 8'hFF, 8'hFD},
    '{32'h000001B0, 8'hFF, 8'h08}, '{32'h00000200, 8'hFF, 8'h00}};
  logic [7:0] vc [8] = '{8'h00, 8'h01, 8'h02, 8'hC8,
                         8'hC9, 8'hCA, 8'hFE, 8'hFF};
  int         pn [4] = '{0, 1, 3, 255};

  assign hready = hreadyout;
  always #25 hclk = ~hclk;

  acc_channel_regs DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mod_tick(mod_tick), .ch1_sample_in(ch1_sample_in),
    .ch1_sample_out(ch1_sample_out), .ch1_muted(ch1_muted),
    .ch1_volume_tenth_db(ch1_volume_tenth_db),
    .ch1_gain_tenth_db(ch1_gain_tenth_db),
    .ch2_source_kind(ch2_source_kind),
    .ch2_input_source(ch2_input_source),
    .ch2_source_analog(ch2_source_analog),
    .ch2_coupling_select(ch2_coupling_select),
    .ch2_input_load_select(ch2_input_load_select),
    .ch2_config_fault(ch2_config_fault),
    .range_enhancer(range_enhancer),
    .automatic_level_control(automatic_level_control),
    .range_compressor(range_compressor));

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask

  task automatic ahb_xfer(input logic [31:0] a, input logic wr,
                          input logic [7:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    htrans <= ACC_HTRANS_NONSEQ;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
    q = hrdata;
    chk_out({10'h000, hready, hresp}, 12'h002);
  endtask

  task automatic ahb_wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb_xfer(a, 1'b1, d, q);
  endtask

  // wait two edges after the write; decoded outputs land on the same edge as the register
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask

  task automatic tick(input logic b);
    ch1_sample_in <= b;
    mod_tick      <= 1'b1;
    @(posedge hclk);
    mod_tick      <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  task automatic check_rst;
    ahb_xfer(32'h000000F8, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h000000C9);
    ahb_xfer(32'h000000FC, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h00000080);
    ahb_xfer(32'h00000100, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h00000000);
    ahb_xfer(32'h00000104, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h00000000);
    ahb_xfer(32'h000001B0, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h00000000);
    chk_out({ch1_muted, ch1_volume_tenth_db[10:0]}, 12'h000);
    chk_out({4'h0, ch1_gain_tenth_db}, 12'h000);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_rst();
    for (int i = 0; i < 8; i++) begin
      ahb_wr(rows[i].a, rows[i].w);
      ahb_xfer(rows[i].a, 1'b0, 8'h00, rd);
      chk_bus(rd, {24'h000000, rows[i].r});
    end
    for (int i = 0; i < 8; i++) begin
      ahb_wr(32'h000000F8, vc[i]);
      settle();
      e = (vc[i] == 8'h00) ? 0 : (int'(vc[i]) - 201) * 5;
      chk_out(ch1_volume_tenth_db, 12'(e));
      chk_out({11'h000, ch1_muted}, {11'h000, vc[i] == 8'h00});
    end
    for (int i = 0; i < 16; i++) begin
      ahb_wr(32'h000000FC, {i[3:0], 4'h0});
      settle();
      chk_out({{4{ch1_gain_tenth_db[7]}}, ch1_gain_tenth_db},
              12'(i - 8));
    end
    for (int i = 0; i < 64; i++) begin
      c = i[5:0];
      an = (c[1:0] < 2'h2);
      ahb_wr(32'h000001B0, {4'h0, c[2], 3'h0});
      ahb_wr(32'h00000104, {c[0], c[1:0], c[5], c[3:2], 1'b0, c[4]});
      settle();
      ex2 = {c[0], c[1:0], an, c[5] & an, an ? c[3:2] : 2'h0,
             (c[1:0] == 2'h3) | (c[3:2] == 2'h3),
             c[4] & ~c[2], c[4] & c[2], 1'b0};
      chk_out({1'b0, ch2_source_kind, ch2_input_source, ch2_source_analog,
               ch2_coupling_select, ch2_input_load_select,
               ch2_config_fault, range_enhancer, automatic_level_control,
               range_compressor},
              {1'b0, ex2});
    end
    // delay line: only ticks after n samples have history to compare
    for (int j = 0; j < 4; j++) begin
      ahb_wr(32'h00000100, pn[j][7:0]);
      hist.delete();
      for (int k = 0; k < pn[j] + 6; k++) begin
        tick(k[0] ^ k[1] ^ k[3]);
        hist.push_back(k[0] ^ k[1] ^ k[3]);
        if (k >= pn[j]) begin
          chk_out({11'h000, ch1_sample_out},
                  {11'h000, hist[k - pn[j]]});
        end
      end
    end
    ahb_wr(32'h00000100, 8'h00);
    ahb_wr(32'h000000F8, 8'h00);
    settle();
    repeat (3) tick(1'b1);
    chk_out({11'h000, ch1_sample_out}, 12'h000);
    ahb_xfer(32'h000000FC, 1'b0, 8'h00, rd);
    chk_bus(rd, 32'h000000F0);
    // second reset in mid-run returns every register to its reset value
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk_bus(hrdata, 32'h00000000);
    chk_out({ch1_muted, 3'h0, ch1_gain_tenth_db}, 12'h000);
    hresetn <= 1'b1;
    settle();
    check_rst();
    final_report();
  end

  initial begin
    #(20000 * 50);
    mismatches++;
    final_report();
  end
endmodule
